// ==== hdl/acc_cmd.sv ====
/*
 text command interpreter for the adapter configuration commands, with
 working parameters, stored profiles and an AXI4-Lite register slave.
 assumes a byte stream from a UART on the same clock and a byte sink.
*/
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "acc_consts.svh"
// Notes on behaviour
// - set command writes the value into the parameter named by its index
// - parameter 0 network timeout, 10 ms units, 1..65535, default 1000
// - tcp timeout below network timeout overrides it for tcp clients
// - parameter 1 association timeout, 10 ms units, 0..65535, default 500
// - parameter 4 serial buffering wait, 10 ms units, default 10
// - parameter 5 per channel scan time in ms, 0..65535, default 20
// - identification query returns oem, hardware or software text for 0..2
// - save command copies working settings into profile 0 or 1
// - profile numbers beyond 1 only with more build-time profiles
// - load command replaces working settings with the stored profile
// - at startup working settings load from the default profile
// - default select that cannot run answers failure, text or code 1
// - factory restore returns defaults, hardware address untouched
// - dump sends working settings and every profile as text
// - commands start with AT, anything else gives an error
// - success answers OK when verbose, else code 0
// - invalid input answers error text when verbose, else code 2
module acc_cmd #(
	// identification texts, values arbitrary
	parameter logic [191:0] OEM_TXT = 192'("OEM-ID\r\n"),
	parameter logic [191:0] HW_TXT  = 192'("HW 1.0\r\n"),
	parameter logic [191:0] SW_TXT  = 192'("SW 1.0\r\n")
) (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	output logic             rx_ready_o,
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	input  wire logic        tx_ready_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	output logic [1:0]       bresp_o,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	input  wire logic [7:0]  araddr_i,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o
);
	import acc_pkg::*;

	acc_state_s st;
	acc_state_s next_st;
	logic       take;
	logic       exec;
	logic       fok;
	logic [1:0] code;
	logic       slv;
	logic [2:0] sl;
	logic [20:0] acc;
	logic [15:0] dv;
	acc_cfg_t   boot_src;

	function automatic logic [191:0] stat_str(input logic vb, input logic [1:0] c);
		logic [191:0] s;
		if (!vb)
			s = 192'({`ACC_CH_ZERO | {6'h00, c}, `ACC_CH_CR, `ACC_CH_LF});
		else if (c == `ACC_RESP_OK)
			s = 192'("OK\r\n");
		else if (c == `ACC_RESP_FAIL)
			s = 192'("ERROR\r\n");
		else
			s = 192'("ERROR: INVALID INPUT\r\n");
		return s;
	endfunction

	function automatic logic [7:0] hexc(input logic [3:0] h);
		return (h < 4'hA) ? (`ACC_CH_ZERO + {4'h0, h}) : (`ACC_CH_HEXA + {4'h0, h});
	endfunction

	function automatic logic is_digit(input logic [7:0] c);
		return (c >= `ACC_CH_ZERO) && (c <= `ACC_CH_NINE);
	endfunction

	function automatic logic [31:0] rd_word(input acc_state_s s, input logic [7:0] a);
		logic [31:0] w;
		w = 32'h00000000;
		if (a == `ACC_OFF_CTRL)
			w[`ACC_CTRL_VERB] = s.verbose;
		else if (a == `ACC_OFF_STAT)
			w = {23'h000000, s.mode != M_PARSE, s.dflt, 2'h0, s.last};
		else if (a >= `ACC_OFF_CFG0 && a <= `ACC_OFF_CFG4)
			w = {16'h0000, s.cfg[3'(a[4:2] - 3'h2)]};
		else if (a == `ACC_OFF_EFF)
			w = {16'h0000, s.eff_net};
		return w;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `ACC_OFF_EFF);
	endfunction

	assign boot_src = st.nv[st.dflt];

	always_comb begin
		next_st = st;
		take = st.rx_ready && rx_valid_i;
		exec = 1'b0;
		fok = 1'b0;
		code = `ACC_RESP_INV;
		slv = 1'b1;
		acc = 21'h000000;
		dv = 16'h0000;
		// parameter ids 0,1,2,4,5; 3 is not supported
		case (st.num)
			4'h0, 4'h1, 4'h2: sl = st.num[2:0];
			4'h4, 4'h5: sl = 3'(st.num[2:0] - 3'h1);
			default: begin
				sl = 3'h0;
				slv = 1'b0;
			end
		endcase
		if (st.tx_valid && tx_ready_i)
			next_st.tx_valid = 1'b0;
		// leading zero bytes of the shifter are skipped, not sent
		if ((!st.tx_valid || tx_ready_i) && st.sh != 192'h0) begin
			if (st.sh[191:184] != 8'h00) begin
				next_st.tx_valid = 1'b1;
				next_st.tx_data = st.sh[191:184];
			end
			next_st.sh = {st.sh[183:0], 8'h00};
		end
		case (st.mode)
			M_BOOT: begin
				next_st.cfg = boot_src;
				next_st.mode = M_PARSE;
			end
			M_PARSE: begin
				if (take && rx_data_i == `ACC_CH_CR) begin
					exec = 1'b1;
					next_st.pst = P_A;
					case (st.cmd)
						C_AT: fok = st.pst == P_CMD;
						C_SET: fok = st.pst == P_VAL && st.has_val;
						default: fok = st.pst == P_END;
					endcase
					if (fok) begin
						case (st.cmd)
							C_AT: code = `ACC_RESP_OK;
							C_SET: begin
								if (slv && !st.ovf && !(sl == `ACC_SLOT_NET && st.val == 17'h0)) begin
									next_st.cfg[sl] = st.val[15:0];
									code = `ACC_RESP_OK;
								end
							end
							C_IDENT: begin
								if (st.num <= `ACC_IDENT_MAX) begin
									code = `ACC_RESP_OK;
									next_st.sh = (st.num == 4'h0) ? OEM_TXT :
										(st.num == 4'h1) ? HW_TXT : SW_TXT;
								end
							end
							C_SAVE: begin
								if (st.num < `ACC_NPROF) begin
									next_st.nv[st.num] = st.cfg;
									code = `ACC_RESP_OK;
								end
							end
							C_LOAD: begin
								if (st.num < `ACC_NPROF) begin
									next_st.cfg = st.nv[st.num];
									code = `ACC_RESP_OK;
								end
							end
							C_DFLT: begin
								code = `ACC_RESP_FAIL;
								if (st.num < `ACC_NPROF) begin
									next_st.dflt = st.num;
									code = `ACC_RESP_OK;
								end
							end
							C_FACT: begin
								// hardware address is not held here
								next_st.cfg = `ACC_FACTORY;
								code = `ACC_RESP_OK;
							end
							default: begin
								next_st.dset = 4'h0;
								next_st.dfld = 3'h0;
								code = `ACC_RESP_OK;
							end
						endcase
					end
					next_st.last = code;
					if (fok && st.cmd == C_DUMP)
						next_st.mode = M_DUMP;
					else if (fok && st.cmd == C_IDENT && code == `ACC_RESP_OK)
						next_st.mode = M_STAT;
					else begin
						next_st.sh = stat_str(st.verbose, code);
						next_st.mode = M_DRAIN;
					end
				end else if (take && rx_data_i != `ACC_CH_LF) begin
					case (st.pst)
						P_A: begin
							next_st.pst = (rx_data_i == `ACC_CH_A) ? P_T : P_BAD;
							next_st.cmd = C_AT;
							next_st.has_val = 1'b0;
							next_st.ovf = 1'b0;
						end
						P_T: next_st.pst = (rx_data_i == `ACC_CH_T) ? P_CMD : P_BAD;
						P_CMD: begin
							next_st.pst = P_NUM;
							if (rx_data_i == `ACC_CH_S)
								next_st.cmd = C_SET;
							else if (rx_data_i == `ACC_CH_I)
								next_st.cmd = C_IDENT;
							else if (rx_data_i == `ACC_CH_Z)
								next_st.cmd = C_LOAD;
							else if (rx_data_i == `ACC_CH_AMP)
								next_st.pst = P_AMP;
							else
								next_st.pst = P_BAD;
						end
						P_AMP: begin
							next_st.pst = P_NUM;
							if (rx_data_i == `ACC_CH_W)
								next_st.cmd = C_SAVE;
							else if (rx_data_i == `ACC_CH_Y)
								next_st.cmd = C_DFLT;
							else if (rx_data_i == `ACC_CH_F) begin
								next_st.cmd = C_FACT;
								next_st.pst = P_END;
							end else if (rx_data_i == `ACC_CH_V) begin
								next_st.cmd = C_DUMP;
								next_st.pst = P_END;
							end else
								next_st.pst = P_BAD;
						end
						P_NUM: begin
							next_st.num = rx_data_i[3:0];
							next_st.pst = !is_digit(rx_data_i) ? P_BAD :
								(st.cmd == C_SET) ? P_EQ : P_END;
						end
						P_EQ: begin
							next_st.pst = (rx_data_i == `ACC_CH_EQ) ? P_VAL : P_BAD;
							next_st.val = 17'h00000;
						end
						P_VAL: begin
							// value past 16 bits is kept as a sticky overflow
							acc = 21'({st.val, 3'h0}) + 21'({st.val, 1'h0}) + 21'(rx_data_i[3:0]);
							next_st.val = acc[16:0];
							next_st.has_val = 1'b1;
							if (acc > 21'h00FFFF)
								next_st.ovf = 1'b1;
							if (!is_digit(rx_data_i))
								next_st.pst = P_BAD;
						end
						default: next_st.pst = P_BAD;
					endcase
				end
			end
			M_DUMP: begin
				if (st.sh == 192'h0) begin
					dv = (st.dset == 4'h0) ? st.cfg[st.dfld] : st.nv[4'(st.dset - 4'h1)][st.dfld];
					next_st.sh = 192'({hexc(dv[15:12]), hexc(dv[11:8]), hexc(dv[7:4]),
						hexc(dv[3:0]), (st.dfld == 3'(`ACC_NFLD - 1)) ? `ACC_CH_LF : `ACC_CH_SP});
					next_st.dfld = 3'(st.dfld + 3'h1);
					if (st.dfld == 3'(`ACC_NFLD - 1)) begin
						next_st.dfld = 3'h0;
						next_st.dset = 4'(st.dset + 4'h1);
						if (st.dset == 4'(`ACC_NPROF))
							next_st.mode = M_STAT;
					end
				end
			end
			M_STAT: begin
				if (st.sh == 192'h0) begin
					next_st.sh = stat_str(st.verbose, st.last);
					next_st.mode = M_DRAIN;
				end
			end
			M_DRAIN: begin
				if (st.sh == 192'h0 && !next_st.tx_valid)
					next_st.mode = M_PARSE;
			end
			default: next_st.mode = M_PARSE;
		endcase
		next_st.eff_net = (next_st.cfg[`ACC_SLOT_TCP] < next_st.cfg[`ACC_SLOT_NET]) ?
			next_st.cfg[`ACC_SLOT_TCP] : next_st.cfg[`ACC_SLOT_NET];
		// register slave: one write and one read outstanding at most
		if (awvalid_i && st.awready) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = awaddr_i;
		end
		if (wvalid_i && st.wready) begin
			next_st.w_got = 1'b1;
			next_st.w_data = wdata_i;
			next_st.w_strb = wstrb_i;
		end
		if (st.bvalid && bready_i)
			next_st.bvalid = 1'b0;
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = mapped(st.aw_addr) ? `ACC_AXI_OKAY : `ACC_AXI_SLVE;
			if (st.aw_addr == `ACC_OFF_CTRL && st.w_strb[0]) begin
				next_st.verbose = st.w_data[`ACC_CTRL_VERB];
				// restart only between commands, a half-parsed line is dropped
				if (st.w_data[`ACC_CTRL_BOOT] && st.mode == M_PARSE &&
						next_st.mode == M_PARSE) begin
					next_st.mode = M_BOOT;
					next_st.pst = P_A;
				end
			end
		end
		if (st.rvalid && rready_i)
			next_st.rvalid = 1'b0;
		if (arvalid_i && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_word(st, araddr_i);
			next_st.rresp = mapped(araddr_i) ? `ACC_AXI_OKAY : `ACC_AXI_SLVE;
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready = !next_st.w_got && !next_st.bvalid;
		next_st.arready = !next_st.rvalid;
		next_st.rx_ready = next_st.mode == M_PARSE;
	end

	// profiles start at factory values; reset_i stands for first power-on
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st <= '0;
			st.nv <= {`ACC_NPROF{`ACC_FACTORY}};
			st.verbose <= 1'b1;
		end else
			st <= next_st;
	end

	assign rx_ready_o = st.rx_ready;
	assign tx_valid_o = st.tx_valid;
	assign tx_data_o = st.tx_data;
	assign awready_o = st.awready;
	assign wready_o = st.wready;
	assign bvalid_o = st.bvalid;
	assign bresp_o = st.bresp;
	assign arready_o = st.arready;
	assign rvalid_o = st.rvalid;
	assign rdata_o = st.rdata;
	assign rresp_o = st.rresp;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_ok_exec(acc_cmd_e c);
		exec && st.cmd == c && code == `ACC_RESP_OK;
	endsequence
	sequence s_bad_lead;
		take && st.mode == M_PARSE && st.pst == P_A && rx_data_i != `ACC_CH_A &&
			rx_data_i != `ACC_CH_CR && rx_data_i != `ACC_CH_LF;
	endsequence

	AST_SET_APPLY: assert property (s_ok_exec(C_SET) |=>
		st.cfg[$past(sl)] == $past(st.val[15:0])) else $error("set value not stored");
	AST_NET_NONZERO: assert property (st.mode != M_BOOT |->
		st.cfg[`ACC_SLOT_NET] != 16'h0000) else $error("network timeout is zero");
	AST_EFF_MIN: assert property (st.mode != M_BOOT |=> st.eff_net ==
		((st.cfg[2] < st.cfg[0]) ? st.cfg[2] : st.cfg[0])) else $error("bad effective timeout");
	AST_SAVE: assert property (s_ok_exec(C_SAVE) |=>
		st.nv[$past(st.num)] == $past(st.cfg)) else $error("profile not saved");
	AST_NV_ONLY_SAVE: assert property (!exec || st.cmd != C_SAVE |=>
		$stable(st.nv)) else $error("profile changed without save");
	AST_LOAD: assert property (s_ok_exec(C_LOAD) |=>
		st.cfg == st.nv[$past(st.num)]) else $error("profile not loaded");
	// the release edge still clears cfg, so an attempt begun under reset is skipped
	AST_BOOT: assert property (st.mode == M_BOOT && !reset_i |=>
		st.cfg == $past(boot_src) && st.rx_ready) else $error("startup load wrong");
	AST_DFLT_FAIL: assert property (exec && st.cmd == C_DFLT && fok &&
		st.num >= `ACC_NPROF |=> st.sh == stat_str($past(st.verbose), `ACC_RESP_FAIL)
		&& $stable(st.dflt)) else $error("default select failure wrong");
	AST_FACT: assert property (s_ok_exec(C_FACT) |=>
		st.cfg == `ACC_FACTORY) else $error("factory values not restored");
	AST_BAD_LEAD: assert property (s_bad_lead |=> st.pst == P_BAD)
		else $error("bad lead not caught");
	AST_INVAL: assert property (exec && code == `ACC_RESP_INV |=>
		st.sh == stat_str($past(st.verbose), `ACC_RESP_INV) && $stable(st.cfg))
		else $error("invalid input answer wrong");
endmodule

// ==== hdl/acc_consts.svh ====
/*
 constants of the adapter configuration command block: offsets, fields,
 reset values, characters and answer codes.
 assumes inclusion by the package and by the design file.
*/
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
// build-time profile count and number of stored parameters
`define ACC_NPROF     2
`define ACC_NFLD      5
// parameter slots: ids 0,1,2,4,5 map to slots 0..4
`define ACC_SLOT_NET  3'h0
`define ACC_SLOT_TCP  3'h2
// factory values, slot 4 down to slot 0: scan, nagle, tcp, assoc, net
`define ACC_FACTORY   {16'h0014, 16'h000A, 16'h03E8, 16'h01F4, 16'h03E8}
`define ACC_IDENT_MAX 4'h2
// answer codes
`define ACC_RESP_OK   2'h0
`define ACC_RESP_FAIL 2'h1
`define ACC_RESP_INV  2'h2
// register byte offsets
`define ACC_OFF_CTRL  8'h00
`define ACC_OFF_STAT  8'h04
`define ACC_OFF_CFG0  8'h08
`define ACC_OFF_CFG4  8'h18
`define ACC_OFF_EFF   8'h1C
`define ACC_CTRL_VERB 0
`define ACC_CTRL_BOOT 1
`define ACC_AXI_OKAY  2'h0
`define ACC_AXI_SLVE  2'h2
// characters
`define ACC_CH_A      8'h41
`define ACC_CH_T      8'h54
`define ACC_CH_S      8'h53
`define ACC_CH_I      8'h49
`define ACC_CH_Z      8'h5A
`define ACC_CH_AMP    8'h26
`define ACC_CH_W      8'h57
`define ACC_CH_Y      8'h59
`define ACC_CH_F      8'h46
`define ACC_CH_V      8'h56
`define ACC_CH_EQ     8'h3D
`define ACC_CH_CR     8'h0D
`define ACC_CH_LF     8'h0A
`define ACC_CH_SP     8'h20
`define ACC_CH_ZERO   8'h30
`define ACC_CH_NINE   8'h39
`define ACC_CH_HEXA   8'h37
`endif

// ==== hdl/acc_pkg.sv ====
/*
 types of the adapter configuration command block.
 assumes acc_consts.svh on the include path.
*/
package acc_pkg;
`include "acc_consts.svh"
	typedef logic [`ACC_NFLD-1:0][15:0] acc_cfg_t;
	typedef enum logic [2:0] {M_BOOT, M_PARSE, M_DUMP, M_STAT, M_DRAIN} acc_mode_e;
	typedef enum logic [3:0] {P_A, P_T, P_CMD, P_AMP, P_NUM, P_EQ, P_VAL, P_END,
		P_BAD} acc_pst_e;
	typedef enum logic [2:0] {C_AT, C_SET, C_IDENT, C_SAVE, C_LOAD, C_DFLT, C_FACT,
		C_DUMP} acc_cmd_e;
	typedef struct packed {
		acc_mode_e                  mode;
		acc_pst_e                   pst;
		acc_cmd_e                   cmd;
		logic [3:0]                 num;
		logic [16:0]                val;
		logic                       has_val;
		logic                       ovf;
		acc_cfg_t                   cfg;
		acc_cfg_t [`ACC_NPROF-1:0]  nv;
		logic [3:0]                 dflt;
		logic                       verbose;
		logic [1:0]                 last;
		logic [15:0]                eff_net;
		logic [191:0]               sh;
		logic [3:0]                 dset;
		logic [2:0]                 dfld;
		logic                       rx_ready;
		logic                       tx_valid;
		logic [7:0]                 tx_data;
		logic                       aw_got;
		logic                       w_got;
		logic [7:0]                 aw_addr;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		logic                       awready;
		logic                       wready;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [1:0]                 rresp;
		logic [31:0]                rdata;
	} acc_state_s;
endpackage

// ==== verif/acc_host.sv ====
/*
 serial host model: sends command lines byte by byte and collects answer text.
 assumes the interpreter's byte handshake on the same clock.
*/
`timescale 1ns/1ps
module acc_host (
	input  wire logic       ref_clk_i,
	input  wire logic       rx_ready_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            tx_ready_o
);
	logic  slow = 1'b0;
	string got  = "";
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
		tx_ready_o = 1'b1;
	end
	// sink stalls every other cycle when slow, to hold answer bytes
	always @(posedge ref_clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got = $sformatf("%s%c", got, tx_data_i);
		end
		tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
	end
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			rx_valid_o <= 1'b1;
			rx_data_o  <= s[i];
			do @(posedge ref_clk_i); while (!rx_ready_i);
		end
		rx_valid_o <= 1'b0;
		// released line shows the inverse, not a stale byte
		rx_data_o  <= ~s[s.len()-1];
	endtask
endmodule

// ==== verif/adapter_config_commands_bench.sv ====
/*
 bench for the configuration command interpreter: host model on the serial
 side, AXI4-Lite master tasks on the register side.
 assumes acc_consts.svh on the include path.
*/
`timescale 1ns/1ps
`include "acc_consts.svh"
module adapter_config_commands_bench;
	import acc_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        reset_i   = 1'b1;
	logic        rx_valid, rx_ready, tx_valid, tx_ready;
	logic [7:0]  rx_data, tx_data, awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp, r;
	int          n_fail = 0;
	int          comparisons = 0;
	localparam string F = "03E8 01F4 03E8 000A 0014\n";
	logic [15:0] fac [5] = '{16'h03E8, 16'h01F4, 16'h03E8, 16'h000A, 16'h0014};
	always #4 ref_clk_i = ~ref_clk_i;
	acc_host host (.ref_clk_i(ref_clk_i), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
		.tx_data_i(tx_data), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.tx_ready_o(tx_ready));
	acc_cmd uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .rx_valid_i(rx_valid),
		.rx_data_i(rx_data), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
		.tx_data_o(tx_data), .tx_ready_i(tx_ready), .awvalid_i(awvalid),
		.awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready),
		.wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid), .bready_i(bready),
		.bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
		.rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp));
	task automatic stop_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input bit ok, input string msg);
		comparisons++;
		if (!ok) begin
			n_fail++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	task automatic cmd(input string s, input string exp);
		int n;
		host.got = "";
		host.send(s);
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (rx_ready !== 1'b1 && n < 3000);
		check(n < 3000 && host.got == exp, {"answer to ", s});
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 1'b1;
		w  = 1'b1;
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hF;
		bready  <= 1'b1;
		while (aw || w) begin
			@(posedge ref_clk_i);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk_i); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		do @(posedge ref_clk_i); while (!arready);
		arvalid <= 1'b0;
		do @(posedge ref_clk_i); while (!rvalid);
		rready <= 1'b0;
		check(rdata === e && rresp === er, "register read");
		@(posedge ref_clk_i);
	endtask
	// hang guard well beyond the expected run
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		n_fail++;
		$display("ERROR %0t watchdog expired", $time);
		stop_test();
	end
	initial begin
		repeat (6) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		for (int i = 0; i < 5; i++) begin
			rdchk(`ACC_OFF_CFG0 + 8'(4 * i), {16'h0, fac[i]}, `ACC_AXI_OKAY);
		end
		rdchk(`ACC_OFF_EFF, 32'h03E8, `ACC_AXI_OKAY);
		rdchk(8'h20, 32'h0, `ACC_AXI_SLVE);
		axi_wr(8'h24, 32'h1);
		check(r === `ACC_AXI_SLVE, "unmapped write");
		axi_wr(`ACC_OFF_CFG0, 32'h7);
		check(r === `ACC_AXI_OKAY, "read-only write");
		rdchk(`ACC_OFF_CFG0, 32'h03E8, `ACC_AXI_OKAY);
		$display("test reset and map done");
		cmd("AT\r", "OK\r\n");
		cmd("XT\r", "ERROR: INVALID INPUT\r\n");
		cmd("ATS0=700\r", "OK\r\n");
		rdchk(`ACC_OFF_EFF, 32'h02BC, `ACC_AXI_OKAY);
		cmd("ATS2=300\r", "OK\r\n");
		rdchk(`ACC_OFF_EFF, 32'h012C, `ACC_AXI_OKAY);
		cmd("ATS5=65535\r", "OK\r\n");
		cmd("ATS0=0\r", "ERROR: INVALID INPUT\r\n");
		cmd("ATS1=65536\r", "ERROR: INVALID INPUT\r\n");
		cmd("ATS3=1\r", "ERROR: INVALID INPUT\r\n");
		rdchk(`ACC_OFF_CFG0, 32'h02BC, `ACC_AXI_OKAY);
		rdchk(`ACC_OFF_CFG0 + 8'h04, 32'h01F4, `ACC_AXI_OKAY);
		$display("test set parameter done");
		cmd("ATI0\r", "OEM-ID\r\nOK\r\n");
		cmd("ATI1\r", "HW 1.0\r\nOK\r\n");
		cmd("ATI2\r", "SW 1.0\r\nOK\r\n");
		cmd("ATI3\r", "ERROR: INVALID INPUT\r\n");
		$display("test identification done");
		cmd("AT&W1\r", "OK\r\n");
		cmd("AT&W2\r", "ERROR: INVALID INPUT\r\n");
		cmd("ATS0=5\r", "OK\r\n");
		rdchk(`ACC_OFF_CFG0, 32'h0005, `ACC_AXI_OKAY);
		cmd("ATZ1\r", "OK\r\n");
		rdchk(`ACC_OFF_CFG0, 32'h02BC, `ACC_AXI_OKAY);
		cmd("ATZ2\r", "ERROR: INVALID INPUT\r\n");
		cmd("AT&F\r", "OK\r\n");
		rdchk(`ACC_OFF_CFG0 + 8'h10, 32'h0014, `ACC_AXI_OKAY);
		rdchk(`ACC_OFF_CFG0, 32'h03E8, `ACC_AXI_OKAY);
		host.slow = 1'b1;
		cmd("AT&V\r", {F, F, "02BC 01F4 012C 000A FFFF\n", "OK\r\n"});
		host.slow = 1'b0;
		$display("test profiles done");
		cmd("AT&Y2\r", "ERROR\r\n");
		// host selects the saved profile as power-on default
		cmd("AT&Y1\r", "OK\r\n");
		rdchk(`ACC_OFF_STAT, 32'h0010, `ACC_AXI_OKAY);
		axi_wr(`ACC_OFF_CTRL, 32'h3);
		repeat (4) @(posedge ref_clk_i);
		rdchk(`ACC_OFF_CFG0, 32'h02BC, `ACC_AXI_OKAY);
		rdchk(`ACC_OFF_EFF, 32'h012C, `ACC_AXI_OKAY);
		$display("test startup load done");
		axi_wr(`ACC_OFF_CTRL, 32'h0);
		cmd("AT\r", "0\r\n");
		cmd("XT\r", "2\r\n");
		cmd("AT&Y3\r", "1\r\n");
		axi_wr(`ACC_OFF_CTRL, 32'h1);
		rdchk(`ACC_OFF_CTRL, 32'h1, `ACC_AXI_OKAY);
		$display("test terse answers done");
		stop_test();
	end
endmodule
